// [pkg/gvch_pkg.sv]
// Constants and types for the pin and voltage command handler.
// Assumes a framing layer that delivers whole decoded commands.
package gvch_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_PINS = 8;
    localparam int PIN_IDX_W = 3;

    // ----------------------------------------------------------------
    // Opcodes and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_READ_PIN = 8'h09;
    localparam logic [7:0] OP_PIN_IRQ = 8'h0A;
    localparam logic [7:0] OP_MEASURE = 8'h0B;
    localparam logic [1:0] LEN_READ_PIN = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;

    localparam logic [7:0] EDGE_FALL = 8'h00;
    localparam logic [7:0] EDGE_RISE = 8'h01;
    localparam logic [7:0] EDGE_ANY = 8'h02;
    localparam logic [7:0] EDGE_OFF = 8'h03;

    localparam logic [7:0] SRC_ADC_PIN = 8'h00;
    localparam logic [7:0] SRC_SUPPLY = 8'h01;

    localparam logic [7:0] FMT_INT_MV = 8'h00;
    localparam logic [7:0] FMT_FLT_MV = 8'h01;
    localparam logic [7:0] FMT_FLT_V = 8'h02;

    localparam logic [7:0] LEVEL_LOW = 8'h00;
    localparam logic [7:0] LEVEL_HIGH = 8'h01;

    localparam logic [2:0] RSP_LEN_NONE = 3'h0;
    localparam logic [2:0] RSP_LEN_BYTE = 3'h1;
    localparam logic [2:0] RSP_LEN_WORD = 3'h4;

    // ----------------------------------------------------------------
    // Pin modes and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_HIZ = 2'h0;
    localparam logic [1:0] MODE_INPUT = 2'h1;
    localparam logic [1:0] MODE_LOW = 2'h2;
    localparam logic [1:0] MODE_HIGH = 2'h3;
    localparam logic [1:0] RST_PIN_MODE = MODE_HIZ;
    localparam logic [1:0] RST_EDGE_CFG = 2'h3;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_PIN_MODE = 8'h08;
    localparam logic [7:0] REG_PIN_LEVEL = 8'h0C;
    localparam logic [7:0] REG_EDGE_CFG = 8'h10;
    localparam int STAT_W = 9;
    localparam int STAT_NACK_BIT = 8;
    localparam logic [8:0] RST_MASK = 9'h000;

    // ----------------------------------------------------------------
    // Float scaling: 0.001 = 1.024 * 2^-10
    // ----------------------------------------------------------------
    localparam logic [23:0] MILLI_MANT = 24'h83126E;
    localparam logic [7:0] MILLI_EXP = 8'h0A;
    localparam logic [7:0] FLT_BIAS = 8'h7F;

    typedef enum logic [1:0] {GVCH_IDLE, GVCH_MEAS} gvch_state_t;

endpackage : gvch_pkg

// [design/gvch_top.sv]
// Pin read, pin interrupt and voltage measurement command handler.
// Takes whole decoded commands, reads the pins (never drives them), drives an external converter,
// and returns one reply per command.
`timescale 1ns/1ns
`default_nettype none

module gvch_top
    import gvch_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    // Command in
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic [1:0] CMD_LEN,
    input wire logic [7:0] CMD_ARG0,
    input wire logic [7:0] CMD_ARG1,
    // Reply out
    output logic RSP_VALID,
    output logic RSP_ACK,
    output logic [2:0] RSP_LEN,
    output logic [31:0] RSP_DATA,
    // Pins
    input wire logic [NUM_PINS-1:0] GPIO_IN,
    output logic [NUM_PINS-1:0] GPIO_OUT,
    output logic [NUM_PINS-1:0] GPIO_OE,
    // Converter
    output logic ADC_REQ,
    output logic [7:0] ADC_SRC,
    input wire logic ADC_DONE,
    input wire logic [31:0] ADC_MV,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic IRQ
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] gvch_to_float(input logic [31:0] v);
        logic [4:0] msb;
        logic [31:0] norm;
        logic [7:0] expo;
        msb = 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (v[i])
            begin
                msb = 5'(i);
            end
        end
        norm = v << (5'h1F - msb);
        expo = FLT_BIAS + {3'h0, msb};
        if (v == 32'h0)
        begin
            return 32'h0;
        end
        return {1'b0, expo, norm[30:8]};
    endfunction : gvch_to_float

    // Multiply a positive float by 0.001, truncating
    function automatic logic [31:0] gvch_milli(input logic [31:0] f);
        logic [47:0] prod;
        logic [7:0] expo;
        prod = {1'b1, f[22:0]} * MILLI_MANT;
        expo = f[30:23] - MILLI_EXP;
        if (f == 32'h0)
        begin
            return 32'h0;
        end
        if (prod[47])
        begin
            return {1'b0, expo + 8'h01, prod[46:24]};
        end
        return {1'b0, expo, prod[45:23]};
    endfunction : gvch_milli

    function automatic logic fmt_ok(input logic [7:0] c);
        return (c == FMT_INT_MV) || (c == FMT_FLT_MV) || (c == FMT_FLT_V);
    endfunction : fmt_ok

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    gvch_state_t state;
    logic [7:0] meas_fmt;
    logic [1:0] pin_mode [NUM_PINS];
    logic [1:0] edge_cfg [NUM_PINS];
    logic [NUM_PINS-1:0] pin_prev;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [PIN_IDX_W-1:0] idx;
    logic idx_ok;
    logic take;
    logic do_read;
    logic do_irq;
    logic do_meas;
    logic bad;

    assign CMD_READY = (state == GVCH_IDLE);
    assign take = CMD_VALID && CMD_READY;
    assign idx = CMD_ARG0[PIN_IDX_W-1:0];
    assign idx_ok = ({24'h0, CMD_ARG0} < NUM_PINS);
    assign do_read = take && (CMD_OPCODE == OP_READ_PIN)
        && (CMD_LEN == LEN_READ_PIN) && idx_ok;
    assign do_irq = take && (CMD_OPCODE == OP_PIN_IRQ)
        && (CMD_LEN == LEN_TWO) && idx_ok
        && (CMD_ARG1 <= EDGE_OFF);
    assign do_meas = take && (CMD_OPCODE == OP_MEASURE)
        && (CMD_LEN == LEN_TWO)
        && ((CMD_ARG0 == SRC_ADC_PIN) || (CMD_ARG0 == SRC_SUPPLY))
        && fmt_ok(CMD_ARG1);
    assign bad = take && !do_read && !do_irq && !do_meas;

    // ----------------------------------------------------------------
    // Sequencer and converter request
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state <= GVCH_IDLE;
            meas_fmt <= FMT_INT_MV;
            ADC_REQ <= 1'b0;
            ADC_SRC <= SRC_ADC_PIN;
        end
        else
        begin
            ADC_REQ <= 1'b0;
            unique case (state)
                GVCH_IDLE:
                begin
                    if (do_meas)
                    begin
                        state <= GVCH_MEAS;
                        meas_fmt <= CMD_ARG1;
                        ADC_REQ <= 1'b1;
                        ADC_SRC <= CMD_ARG0;
                    end
                end
                GVCH_MEAS:
                begin
                    if (ADC_DONE)
                    begin
                        state <= GVCH_IDLE;
                    end
                end
                default:
                begin
                    state <= GVCH_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Reply
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            RSP_VALID <= 1'b0;
            RSP_ACK <= 1'b0;
            RSP_LEN <= RSP_LEN_NONE;
            RSP_DATA <= 32'h0;
        end
        else
        begin
            RSP_VALID <= 1'b0;
            if (bad)
            begin
                RSP_VALID <= 1'b1;
                RSP_ACK <= 1'b0;
                RSP_LEN <= RSP_LEN_NONE;
                RSP_DATA <= 32'h0;
            end
            else if (do_read)
            begin
                RSP_VALID <= 1'b1;
                RSP_ACK <= 1'b1;
                RSP_LEN <= RSP_LEN_BYTE;
                RSP_DATA <= {24'h0, GPIO_IN[idx] ? LEVEL_HIGH
                                                 : LEVEL_LOW};
            end
            else if (do_irq)
            begin
                RSP_VALID <= 1'b1;
                RSP_ACK <= 1'b1;
                RSP_LEN <= RSP_LEN_NONE;
                RSP_DATA <= 32'h0;
            end
            else if ((state == GVCH_MEAS) && ADC_DONE)
            begin
                RSP_VALID <= 1'b1;
                RSP_ACK <= 1'b1;
                RSP_LEN <= RSP_LEN_WORD;
                if (meas_fmt == FMT_FLT_MV)
                begin
                    RSP_DATA <= gvch_to_float(ADC_MV);
                end
                else if (meas_fmt == FMT_FLT_V)
                begin
                    RSP_DATA <= gvch_milli(gvch_to_float(ADC_MV));
                end
                else
                begin
                    RSP_DATA <= ADC_MV;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin mode, edge setting and pin drivers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_pin
            always_ff @(posedge CLK_SYS)
            begin
                if (RST)
                begin
                    pin_mode[g] <= RST_PIN_MODE;
                    edge_cfg[g] <= RST_EDGE_CFG;
                end
                else if (do_irq && (idx == PIN_IDX_W'(g)))
                begin
                    edge_cfg[g] <= CMD_ARG1[1:0];
                    pin_mode[g] <= (CMD_ARG1 == EDGE_OFF)
                        ? MODE_HIZ : MODE_INPUT;
                end
            end
            assign GPIO_OE[g] = (pin_mode[g] == MODE_LOW)
                || (pin_mode[g] == MODE_HIGH);
            assign GPIO_OUT[g] = (pin_mode[g] == MODE_HIGH);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Edge events and interrupt status
    // ----------------------------------------------------------------
    logic [STAT_W-1:0] events;
    logic [STAT_W-1:0] clr;

    always_comb
    begin
        events = '0;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            unique case (edge_cfg[i])
                EDGE_FALL[1:0]: events[i] = pin_prev[i] && !GPIO_IN[i];
                EDGE_RISE[1:0]: events[i] = !pin_prev[i] && GPIO_IN[i];
                EDGE_ANY[1:0]: events[i] = pin_prev[i] != GPIO_IN[i];
                EDGE_OFF[1:0]: events[i] = 1'b0;
            endcase
        end
        events[STAT_NACK_BIT] = bad;
    end

    assign clr = (REG_WR && (REG_ADDR == REG_STATUS))
        ? REG_WDATA[STAT_W-1:0] : '0;

    always_ff @(posedge CLK_SYS)
    begin
        pin_prev <= RST ? '0 : GPIO_IN;
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge CLK_SYS)
    begin
        status <= RST ? '0 : ((status & ~clr) | events);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            mask <= RST_MASK;
        end
        else if (REG_WR && (REG_ADDR == REG_MASK))
        begin
            mask <= REG_WDATA[STAT_W-1:0];
        end
    end

    assign IRQ = |(status & mask);

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    logic [2*NUM_PINS-1:0] mode_flat;
    logic [2*NUM_PINS-1:0] edge_flat;

    always_comb
    begin
        mode_flat = '0;
        edge_flat = '0;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            mode_flat[2*i +: 2] = pin_mode[i];
            edge_flat[2*i +: 2] = edge_cfg[i];
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST || !REG_RD)
        begin
            REG_RDATA <= 32'h0;
        end
        else
        begin
            unique case (REG_ADDR)
                REG_STATUS: REG_RDATA <= {23'h0, status};
                REG_MASK: REG_RDATA <= {23'h0, mask};
                REG_PIN_MODE: REG_RDATA <= {16'h0, mode_flat};
                REG_PIN_LEVEL: REG_RDATA <= {24'h0, GPIO_IN};
                REG_EDGE_CFG: REG_RDATA <= {16'h0, edge_flat};
                default: REG_RDATA <= 32'h0;
            endcase
        end
    end

endmodule : gvch_top

`default_nettype wire

// [testbench/gvch_checker.sv]
// Port assertions for the pin and voltage command handler.
// Bound to gvch_top; sees only its ports, single clock domain.
`timescale 1ns/1ns
`default_nettype none

module gvch_checker
    import gvch_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire logic CMD_READY,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic [1:0] CMD_LEN,
    input wire logic [7:0] CMD_ARG0,
    input wire logic [7:0] CMD_ARG1,
    input wire logic RSP_VALID,
    input wire logic RSP_ACK,
    input wire logic [2:0] RSP_LEN,
    input wire logic [31:0] RSP_DATA,
    input wire logic [NUM_PINS-1:0] GPIO_IN,
    input wire logic [NUM_PINS-1:0] GPIO_OE,
    input wire logic ADC_REQ,
    input wire logic [7:0] ADC_SRC,
    input wire logic ADC_DONE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    wire logic tk = CMD_VALID && CMD_READY;
    wire logic rd_ok = tk && CMD_OPCODE == OP_READ_PIN
        && CMD_LEN == LEN_READ_PIN && CMD_ARG0 < 8'h08;
    wire logic irq_ok = tk && CMD_OPCODE == OP_PIN_IRQ
        && CMD_LEN == LEN_TWO && CMD_ARG0 < 8'h08 && CMD_ARG1 < 8'h04;
    wire logic ms_ok = tk && CMD_OPCODE == OP_MEASURE
        && CMD_LEN == LEN_TWO && CMD_ARG0 < 8'h02 && CMD_ARG1 < 8'h03;
    wire logic bad = tk && !rd_ok && !irq_ok && !ms_ok;

    AST_READ_REPLY: assert property (rd_ok |=> RSP_VALID
        && RSP_ACK && RSP_LEN == RSP_LEN_BYTE
        && RSP_DATA == {31'h0, $past(GPIO_IN[CMD_ARG0[2:0]])})
        else $error("pin read reply wrong");
    AST_IRQ_ACK: assert property (irq_ok |=> RSP_VALID
        && RSP_ACK && RSP_LEN == RSP_LEN_NONE)
        else $error("pin irq reply wrong");
    AST_NO_DRIVE: assert property (GPIO_OE == '0)
        else $error("pin driven");
    AST_MEAS_REQ: assert property (ms_ok |=> ADC_REQ
        && !CMD_READY && ADC_SRC == $past(CMD_ARG0))
        else $error("measure start wrong");
    AST_MEAS_REPLY: assert property (!CMD_READY && ADC_DONE |=>
        RSP_VALID && RSP_ACK && RSP_LEN == RSP_LEN_WORD && CMD_READY)
        else $error("measure reply wrong");
    AST_REJECT: assert property (bad |=> RSP_VALID && !RSP_ACK
        && RSP_LEN == RSP_LEN_NONE && RSP_DATA == 32'h0)
        else $error("reject reply wrong");
    AST_REJ_NO_ADC: assert property (bad |=>
        !ADC_REQ && CMD_READY)
        else $error("reject started converter");
    AST_RSP_CAUSE: assert property (RSP_VALID |->
        $past(tk) || $past(ADC_DONE)) else $error("reply without cause");

    cover property (rd_ok);
    cover property (irq_ok);
    cover property (ms_ok ##1 ADC_REQ);
    cover property (bad);
endmodule : gvch_checker

bind gvch_top gvch_checker i_gvch_checker (.CLK_SYS, .RST, .CMD_VALID,
    .CMD_READY, .CMD_OPCODE, .CMD_LEN, .CMD_ARG0, .CMD_ARG1, .RSP_VALID,
    .RSP_ACK, .RSP_LEN, .RSP_DATA, .GPIO_IN, .GPIO_OE, .ADC_REQ, .ADC_SRC,
    .ADC_DONE);

`default_nettype wire

// [testbench/gvch_adc_model.sv]
// Converter model: answers each request after a chosen delay.
// Driven by the handler's request and source outputs.
`timescale 1ns/1ns
`default_nettype none

module gvch_adc_model
    import gvch_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [7:0] src,
    input wire logic [3:0] dly,
    input wire logic [31:0] pin_mv,
    input wire logic [31:0] sup_mv,
    output logic done,
    output logic [31:0] mv
);
    logic busy;
    logic [3:0] cnt;
    wire logic [31:0] val = (src == SRC_SUPPLY) ? sup_mv : pin_mv;

    // Result bus is only meaningful with done
    assign mv = done ? val : ~val;

    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        if (rst)
            busy <= 1'b0;
        else if (req)
        begin
            busy <= 1'b1;
            cnt <= dly;
        end
        else if (busy && cnt == 4'h0)
        begin
            busy <= 1'b0;
            done <= 1'b1;
        end
        else if (busy)
            cnt <= cnt - 4'h1;
    end
endmodule : gvch_adc_model

`default_nettype wire

// [testbench/gvch_tb_top.sv]
// Self-checking bench for the pin and voltage command handler.
// Uses gvch_adc_model as the converter and the checker by bind.
`timescale 1ns/1ns
`default_nettype none

module gvch_tb_top
    import gvch_pkg::*;
;
    logic CLK_SYS = 1'b0, RST = 1'b1, CMD_VALID = 1'b0;
    logic REG_WR = 1'b0, REG_RD = 1'b0;
    logic [7:0] CMD_OPCODE = 8'h0, CMD_ARG0 = 8'h0, CMD_ARG1 = 8'h0;
    logic [7:0] REG_ADDR = 8'h0;
    logic [1:0] CMD_LEN = 2'h0;
    logic [31:0] REG_WDATA = 32'h0, pin_mv = 32'h3E8, sup_mv = 32'h7D0;
    logic [NUM_PINS-1:0] GPIO_IN = '0;
    logic [3:0] dly = 4'h0;
    wire logic CMD_READY, RSP_VALID, RSP_ACK, ADC_REQ, ADC_DONE, IRQ;
    wire logic [2:0] RSP_LEN;
    wire logic [31:0] RSP_DATA, ADC_MV, REG_RDATA;
    wire logic [7:0] ADC_SRC;
    wire logic [NUM_PINS-1:0] GPIO_OUT, GPIO_OE;
    int miscompares = 0;
    int tests_run = 0;

    always #5 CLK_SYS = ~CLK_SYS;

    gvch_top i_gvch_top (.CLK_SYS, .RST, .CMD_VALID, .CMD_READY, .CMD_OPCODE,
        .CMD_LEN, .CMD_ARG0, .CMD_ARG1, .RSP_VALID, .RSP_ACK, .RSP_LEN,
        .RSP_DATA, .GPIO_IN, .GPIO_OUT, .GPIO_OE, .ADC_REQ, .ADC_SRC,
        .ADC_DONE, .ADC_MV, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
        .REG_RDATA, .IRQ);
    gvch_adc_model i_gvch_adc_model (.clk(CLK_SYS), .rst(RST), .req(ADC_REQ),
        .src(ADC_SRC), .dly, .pin_mv, .sup_mv, .done(ADC_DONE), .mv(ADC_MV));

    task automatic final_report;
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] op, input logic [1:0] ln,
        input logic [7:0] a0, a1, input logic ea, input logic [2:0] el,
        input logic [31:0] ed);
        int n = 0;
        @(posedge CLK_SYS);
        CMD_VALID <= 1'b1;
        {CMD_OPCODE, CMD_LEN, CMD_ARG0, CMD_ARG1} <= {op, ln, a0, a1};
        @(posedge CLK_SYS);
        CMD_VALID <= 1'b0;
        #1;
        while (RSP_VALID !== 1'b1 && n < 50)
        begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end
        chk(32'(n < 50), 32'h1, "no reply");
        if (n == 50)
            final_report();
        chk({28'h0, RSP_ACK, RSP_LEN}, {28'h0, ea, el}, "reply kind");
        chk(RSP_DATA, ed, "reply data");
    endtask : cmd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_SYS);
        {REG_RD, REG_ADDR} <= {1'b1, a};
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        #1;
        chk(REG_RDATA, e, "register read");
    endtask : rd

    task automatic t_reset;
        rd(REG_PIN_MODE, 32'h0);
        rd(REG_EDGE_CFG, 32'hFFFF);
    endtask : t_reset

    task automatic t_irq_cfg;
        for (int c = 0; c < 4; c++)
        begin
            cmd(OP_PIN_IRQ, LEN_TWO, 8'h02, 8'(c), 1'b1, RSP_LEN_NONE,
                32'h0);
            rd(REG_PIN_MODE, c == 3 ? 32'h0 : 32'h10);
            rd(REG_EDGE_CFG, 32'hFFCF | (32'(c) << 4));
            chk({16'h0, GPIO_OE, GPIO_OUT}, 32'h0, "pin drive");
        end
    endtask : t_irq_cfg

    task automatic t_edge;
        cmd(OP_PIN_IRQ, LEN_TWO, 8'h01, EDGE_RISE, 1'b1, RSP_LEN_NONE,
            32'h0);
        wr(REG_MASK, 32'h002);
        @(posedge CLK_SYS);
        GPIO_IN <= 8'h02;
        repeat (3) @(posedge CLK_SYS);
        #1;
        chk({31'h0, IRQ}, 32'h1, "edge irq");
        rd(REG_STATUS, 32'h002);
        wr(REG_STATUS, 32'h002);
        chk({31'h0, IRQ}, 32'h0, "irq clear");
        cmd(OP_PIN_IRQ, LEN_TWO, 8'h01, EDGE_FALL, 1'b1, RSP_LEN_NONE,
            32'h0);
        @(posedge CLK_SYS);
        GPIO_IN <= 8'h00;
        repeat (3) @(posedge CLK_SYS);
        rd(REG_STATUS, 32'h002);
        wr(REG_STATUS, 32'h002);
        cmd(OP_PIN_IRQ, LEN_TWO, 8'h01, EDGE_OFF, 1'b1, RSP_LEN_NONE,
            32'h0);
    endtask : t_edge

    task automatic t_read;
        @(posedge CLK_SYS);
        GPIO_IN <= 8'hA5;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            cmd(OP_PIN_IRQ, LEN_TWO, 8'(i), EDGE_ANY, 1'b1, RSP_LEN_NONE,
                32'h0);
            cmd(OP_READ_PIN, LEN_READ_PIN, 8'(i), 8'h0, 1'b1, RSP_LEN_BYTE,
                {24'h0, 8'hA5 >> i & 8'h1});
        end
        @(posedge CLK_SYS);
        GPIO_IN <= 8'h5A;
        repeat (3) @(posedge CLK_SYS);
        rd(REG_STATUS, 32'h0FF);
    endtask : t_read

    task automatic t_meas;
        cmd(OP_MEASURE, LEN_TWO, SRC_SUPPLY, FMT_INT_MV, 1'b1, RSP_LEN_WORD,
            32'h7D0);
        dly <= 4'h7;
        cmd(OP_MEASURE, LEN_TWO, SRC_ADC_PIN, FMT_FLT_MV, 1'b1, RSP_LEN_WORD,
            32'h447A0000);
        cmd(OP_MEASURE, LEN_TWO, SRC_SUPPLY, FMT_FLT_V, 1'b1, RSP_LEN_WORD,
            32'h3FFFFFFE);
        pin_mv <= 32'h0;
        cmd(OP_MEASURE, LEN_TWO, SRC_ADC_PIN, FMT_FLT_V, 1'b1, RSP_LEN_WORD,
            32'h0);
    endtask : t_meas

    task automatic t_reject;
        logic [25:0] bad [7];
        bad = '{{OP_READ_PIN, 2'h1, 16'h0800}, {OP_PIN_IRQ, 2'h2, 16'h0004},
            {OP_MEASURE, 2'h2, 16'h0200}, {OP_MEASURE, 2'h2, 16'h0003},
            {OP_READ_PIN, 2'h2, 16'h0}, {8'h0C, 2'h1, 16'h0},
            {OP_PIN_IRQ, 2'h2, 16'h0800}};
        wr(REG_STATUS, 32'h1FF);
        foreach (bad[i])
            cmd(bad[i][25:18], bad[i][17:16], bad[i][15:8], bad[i][7:0],
                1'b0, RSP_LEN_NONE, 32'h0);
        rd(REG_STATUS, 32'h100);
        rd(REG_PIN_MODE, 32'h5555);
        rd(REG_EDGE_CFG, 32'hAAAA);
        wr(REG_MASK, 32'h100);
        chk({31'h0, IRQ}, 32'h1, "reject irq");
        wr(REG_STATUS, 32'h100);
        chk({31'h0, IRQ}, 32'h0, "reject clear");
        rd(8'h14, 32'h0);
    endtask : t_reject

    initial
    begin
        repeat (8) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_reset();
        t_irq_cfg();
        t_edge();
        t_read();
        t_meas();
        t_reject();
        final_report();
    end
endmodule : gvch_tb_top

`default_nettype wire
